/* File: rtl/pmfpc_pkg.sv */
package pmfpc_pkg;

	// special-function-register addresses
	localparam logic [7:0] ADDR_WRITE_KEY        = 8'hc1;
	localparam logic [7:0] ADDR_POWER_CONTROL    = 8'hc5;
	localparam logic [7:0] ADDR_PM_IRQ_ENABLE    = 8'hec;
	localparam logic [7:0] ADDR_PERIPHERAL_CFG   = 8'hf4;
	localparam logic [7:0] ADDR_BATTERY_SW_CFG   = 8'hf5;
	localparam logic [7:0] ADDR_PM_IRQ_FLAGS     = 8'hf8;
	localparam logic [7:0] ADDR_SCRATCH_ONE      = 8'hfb;
	localparam logic [7:0] ADDR_SCRATCH_TWO      = 8'hfc;
	localparam logic [7:0] ADDR_SCRATCH_THREE    = 8'hfd;
	localparam logic [7:0] ADDR_SCRATCH_FOUR     = 8'hfe;
	localparam logic [7:0] ADDR_INTERRUPT_PIN    = 8'hff;

	localparam logic [7:0] KEY_UNLOCK            = 8'hea;

	// reset values
	localparam logic [7:0] RESET_BYTE            = 8'h00;
	localparam logic [7:0] RESET_FLAGS           = 8'h00;
	localparam logic [7:0] RESET_PIN_CFG         = 8'h00;
	localparam logic [7:0] RESET_KEY             = 8'h00;
	localparam logic       RESET_SOURCE_MAIN     = 1'b1;
	localparam logic       RESET_DC_LOW          = 1'b0;

	// flag bit positions
	localparam int FLAG_SUPPLY_RESTORED   = 7;
	localparam int FLAG_POWER_SAVE_IRQ    = 6;
	localparam int FLAG_VOLTAGE_SAG       = 5;
	localparam int FLAG_RESERVED          = 4;
	localparam int FLAG_DC_INPUT_ADC      = 3;
	localparam int FLAG_BATTERY_MONITOR   = 2;
	localparam int FLAG_BATTERY_SWITCH    = 1;
	localparam int FLAG_DC_INPUT_LOW      = 0;

	// writable bits of flag, enable and pin registers, and the event-flag bits of the flag register
	localparam logic [7:0] FLAG_WRITE_MASK   = 8'hef;
	localparam logic [7:0] ENABLE_WRITE_MASK = 8'haf;
	localparam logic [7:0] PIN_WRITE_MASK    = 8'hef;
	localparam logic [7:0] EVENT_ONLY_MASK   = 8'haf;

	// calibration output timing
	localparam int CLOCK_HZ      = 25_000_000;
	localparam int CAL_HZ_SLOW   = 1;
	localparam int CAL_HZ_512    = 512;
	localparam int CAL_HZ_500    = 500;
	localparam int CAL_HZ_FAST   = 16_000;
	localparam int CAL_CNT_W     = 24;
	localparam int HALF_SLOW     = CLOCK_HZ / (2 * CAL_HZ_SLOW);
	localparam int HALF_512      = CLOCK_HZ / (2 * CAL_HZ_512);
	localparam int HALF_500      = CLOCK_HZ / (2 * CAL_HZ_500);
	localparam logic [CAL_CNT_W-1:0] HALF_FAST = CAL_CNT_W'(CLOCK_HZ / (2 * CAL_HZ_FAST));

	typedef enum logic [1:0] {
		PMFPC_CSEL_1HZ   = 2'b00,
		PMFPC_CSEL_512HZ = 2'b01,
		PMFPC_CSEL_500HZ = 2'b10,
		PMFPC_CSEL_16KHZ = 2'b11
	} pmfpc_csel_t;

	typedef struct packed {
		logic        calibration_out_enable;
		pmfpc_csel_t cal_freq_select;
		logic        reserved;
		logic [2:0]  ext_irq1_pin_function;
		logic        ext_irq0_pin_function;
	} pmfpc_pcfg_t;

	typedef struct packed {
		logic sag;
		logic dc_delta;
		logic dc_ready;
		logic bat_low;
		logic bat_ready;
	} pmfpc_evt_t;

endpackage : pmfpc_pkg

/* File: rtl/pmfpc_cal_div.sv */
`timescale 1ns/10ps
module pmfpc_cal_div
	import pmfpc_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 enable,
	input  wire logic [CAL_CNT_W-1:0] half_count,
	output logic                      cal_q
);

	logic [CAL_CNT_W-1:0] cnt_q;
	logic [CAL_CNT_W-1:0] cnt_d;
	logic                 cal_d;

	// a select change applies to the half-period in progress; a count already at or past the new limit toggles on the next cycle
	always_comb begin
		cnt_d = cnt_q + CAL_CNT_W'(1);
		cal_d = cal_q;
		if (!enable) begin
			cnt_d = '0;
			cal_d = 1'b0;
		end else if (cnt_d >= half_count) begin
			cnt_d = '0;
			cal_d = ~cal_q;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			cal_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			cal_q <= cal_d;
		end
	end

endmodule : pmfpc_cal_div

/* File: rtl/pmfpc_top.sv */
`timescale 1ns/10ps
module pmfpc_top
	import pmfpc_pkg::*;
#(
	parameter int HALF_SLOW_CNT = HALF_SLOW,
	parameter int HALF_512_CNT  = HALF_512,
	parameter int HALF_500_CNT  = HALF_500
) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_we,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       supply_source_main,
	input  wire logic       dc_input_low,
	input  pmfpc_evt_t      monitor_events,
	output logic            cal_out,
	output logic            cal_out_oe,
	output logic            ext_irq0_input_enable,
	output logic            ext_irq1_input_enable,
	output logic            ext_irq1_gpio_select,
	output logic            battery_control_input,
	output logic            power_save_irq,
	output logic      [7:0] power_control,
	output logic      [7:0] peripheral_config,
	output logic      [7:0] battery_switch_config
);

	// flag update: write-0 clears, write-1 keeps, a set in the same cycle wins
	function automatic logic [7:0] sticky_next(
		input logic [7:0] old_val,
		input logic [7:0] set_val,
		input logic       clr_we,
		input logic [7:0] wdata
	);
		logic [7:0] kept;
		kept = clr_we ? (old_val & wdata) : old_val;
		return (kept | set_val) & FLAG_WRITE_MASK;
	endfunction : sticky_next

	function automatic logic hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return addr == target;
	endfunction : hit

	// pin-level inputs from analog monitors cross into the core clock here
	logic       src_meta_q;
	logic       src_sync_q;
	logic       src_prev_q;
	logic       dcl_meta_q;
	logic       dcl_sync_q;
	logic       dcl_prev_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			src_meta_q <= RESET_SOURCE_MAIN;
			src_sync_q <= RESET_SOURCE_MAIN;
			src_prev_q <= RESET_SOURCE_MAIN;
			dcl_meta_q <= RESET_DC_LOW;
			dcl_sync_q <= RESET_DC_LOW;
			dcl_prev_q <= RESET_DC_LOW;
		end else begin
			src_meta_q <= supply_source_main;
			src_sync_q <= src_meta_q;
			src_prev_q <= src_sync_q;
			dcl_meta_q <= dc_input_low;
			dcl_sync_q <= dcl_meta_q;
			dcl_prev_q <= dcl_sync_q;
		end
	end

	logic restore_evt;
	logic switch_evt;
	logic dc_low_evt;

	assign restore_evt = src_sync_q & ~src_prev_q;
	assign switch_evt  = ~src_sync_q & src_prev_q;
	assign dc_low_evt  = dcl_sync_q & ~dcl_prev_q;

	// register state
	logic [7:0]   power_control_q;
	logic [7:0]   power_control_d;
	logic [7:0]   pm_irq_enable_q;
	logic [7:0]   pm_irq_enable_d;
	logic [7:0]   peripheral_config_q;
	logic [7:0]   peripheral_config_d;
	logic [7:0]   battery_switch_config_q;
	logic [7:0]   battery_switch_config_d;
	logic [7:0]   pm_irq_flags_q;
	logic [7:0]   pm_irq_flags_d;
	logic [7:0]   scratch_q [4];
	logic [7:0]   scratch_d [4];
	pmfpc_pcfg_t  interrupt_pin_config_q;
	pmfpc_pcfg_t  interrupt_pin_config_d;
	logic [7:0]   write_key_register_q;
	logic [7:0]   write_key_register_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;
	logic [7:0]   event_set;
	logic [7:0]   event_flags;
	logic         unlocked;

	// key is judged on its value before this write, so one instruction cannot unlock itself
	assign unlocked = write_key_register_q == KEY_UNLOCK;

	always_comb begin
		event_set = '0;
		event_set[FLAG_SUPPLY_RESTORED] = restore_evt;
		event_set[FLAG_VOLTAGE_SAG]     = monitor_events.sag;
		event_set[FLAG_DC_INPUT_ADC]    = monitor_events.dc_delta | monitor_events.dc_ready;
		event_set[FLAG_BATTERY_MONITOR] = monitor_events.bat_low | monitor_events.bat_ready;
		event_set[FLAG_BATTERY_SWITCH]  = switch_evt;
		event_set[FLAG_DC_INPUT_LOW]    = dc_low_evt;
	end

	always_comb begin
		power_control_d         = power_control_q;
		pm_irq_enable_d         = pm_irq_enable_q;
		peripheral_config_d     = peripheral_config_q;
		battery_switch_config_d = battery_switch_config_q;
		interrupt_pin_config_d  = interrupt_pin_config_q;
		write_key_register_d    = write_key_register_q;
		scratch_d               = scratch_q;
		if (sfr_we) begin
			unique case (sfr_addr)
				ADDR_WRITE_KEY:      write_key_register_d    = sfr_wdata;
				ADDR_POWER_CONTROL:  power_control_d         = sfr_wdata;
				ADDR_PM_IRQ_ENABLE:  pm_irq_enable_d         = sfr_wdata & ENABLE_WRITE_MASK;
				ADDR_PERIPHERAL_CFG: peripheral_config_d     = sfr_wdata;
				ADDR_BATTERY_SW_CFG: battery_switch_config_d = sfr_wdata;
				ADDR_SCRATCH_ONE:    scratch_d[0]            = sfr_wdata;
				ADDR_SCRATCH_TWO:    scratch_d[1]            = sfr_wdata;
				ADDR_SCRATCH_THREE:  scratch_d[2]            = sfr_wdata;
				ADDR_SCRATCH_FOUR:   scratch_d[3]            = sfr_wdata;
				ADDR_INTERRUPT_PIN: begin
					if (unlocked) begin
						interrupt_pin_config_d = pmfpc_pcfg_t'(sfr_wdata & PIN_WRITE_MASK);
					end
				end
				default: ;
			endcase
		end
	end

	// power-save flag looks at event flags after this cycle's sets and clears
	// and at the enable being written, so enabling a pending flag raises it at once
	always_comb begin
		logic       flags_we;
		logic [7:0] save_next;
		flags_we = sfr_we && hit(sfr_addr, ADDR_PM_IRQ_FLAGS);
		save_next = '0;
		event_flags = sticky_next(pm_irq_flags_q, event_set, flags_we, sfr_wdata) & EVENT_ONLY_MASK;
		pm_irq_flags_d = event_flags;
		save_next = sticky_next(pm_irq_flags_q,
			{1'b0, |(event_flags & pm_irq_enable_d), 6'h00},
			flags_we, sfr_wdata);
		pm_irq_flags_d[FLAG_POWER_SAVE_IRQ] = save_next[FLAG_POWER_SAVE_IRQ];
		pm_irq_flags_d[FLAG_RESERVED] = 1'b0;
	end

	// read data held in a flop; unmapped addresses answer zero
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_WRITE_KEY:      rdata_d = write_key_register_q;
				ADDR_POWER_CONTROL:  rdata_d = power_control_q;
				ADDR_PM_IRQ_ENABLE:  rdata_d = pm_irq_enable_q;
				ADDR_PERIPHERAL_CFG: rdata_d = peripheral_config_q;
				ADDR_BATTERY_SW_CFG: rdata_d = battery_switch_config_q;
				ADDR_PM_IRQ_FLAGS:   rdata_d = pm_irq_flags_q;
				ADDR_SCRATCH_ONE:    rdata_d = scratch_q[0];
				ADDR_SCRATCH_TWO:    rdata_d = scratch_q[1];
				ADDR_SCRATCH_THREE:  rdata_d = scratch_q[2];
				ADDR_SCRATCH_FOUR:   rdata_d = scratch_q[3];
				ADDR_INTERRUPT_PIN:  rdata_d = 8'(interrupt_pin_config_q);
				default:             rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			power_control_q         <= RESET_BYTE;
			pm_irq_enable_q         <= RESET_BYTE;
			peripheral_config_q     <= RESET_BYTE;
			battery_switch_config_q <= RESET_BYTE;
			pm_irq_flags_q          <= RESET_FLAGS;
			scratch_q               <= '{default: RESET_BYTE};
			interrupt_pin_config_q  <= pmfpc_pcfg_t'(RESET_PIN_CFG);
			write_key_register_q    <= RESET_KEY;
			rdata_q                 <= RESET_BYTE;
		end else begin
			power_control_q         <= power_control_d;
			pm_irq_enable_q         <= pm_irq_enable_d;
			peripheral_config_q     <= peripheral_config_d;
			battery_switch_config_q <= battery_switch_config_d;
			pm_irq_flags_q          <= pm_irq_flags_d;
			scratch_q               <= scratch_d;
			interrupt_pin_config_q  <= interrupt_pin_config_d;
			write_key_register_q    <= write_key_register_d;
			rdata_q                 <= rdata_d;
		end
	end

	// calibration frequency select
	logic [CAL_CNT_W-1:0] half_count;

	always_comb begin
		unique case (interrupt_pin_config_q.cal_freq_select)
			PMFPC_CSEL_1HZ:   half_count = CAL_CNT_W'(HALF_SLOW_CNT);
			PMFPC_CSEL_512HZ: half_count = CAL_CNT_W'(HALF_512_CNT);
			PMFPC_CSEL_500HZ: half_count = CAL_CNT_W'(HALF_500_CNT);
			PMFPC_CSEL_16KHZ: half_count = HALF_FAST;
		endcase
	end

	// 16 kHz comes out slightly fast: the clock does not divide evenly
	pmfpc_cal_div u_cal_div (
		.clock      (clock),
		.reset_n    (reset_n),
		.enable     (interrupt_pin_config_q.calibration_out_enable),
		.half_count (half_count),
		.cal_q      (cal_out)
	);

	logic [2:0] irq1_fn;

	assign irq1_fn               = interrupt_pin_config_q.ext_irq1_pin_function;
	assign cal_out_oe            = interrupt_pin_config_q.calibration_out_enable;
	assign ext_irq0_input_enable = interrupt_pin_config_q.ext_irq0_pin_function;
	assign ext_irq1_gpio_select  = irq1_fn[1:0] == 2'h0;
	assign battery_control_input = irq1_fn[1:0] == 2'h1;
	assign ext_irq1_input_enable = irq1_fn[2:1] == 2'h3;
	assign power_save_irq        = pm_irq_flags_q[FLAG_POWER_SAVE_IRQ];
	assign power_control         = power_control_q;
	assign peripheral_config     = peripheral_config_q;
	assign battery_switch_config = battery_switch_config_q;
	assign sfr_rdata             = rdata_q;

	a_key_blocks_write: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_we && sfr_addr == ADDR_INTERRUPT_PIN && write_key_register_q != KEY_UNLOCK
		|=> $stable(interrupt_pin_config_q))
		else $error("pin config changed while locked");

	a_key_lets_write: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_we && sfr_addr == ADDR_INTERRUPT_PIN && write_key_register_q == KEY_UNLOCK
		|=> 8'(interrupt_pin_config_q) == ($past(sfr_wdata) & PIN_WRITE_MASK))
		else $error("unlocked pin config write not taken");

	a_cal_off_clear: assert property (@(posedge clock) disable iff (!reset_n)
		!interrupt_pin_config_q.calibration_out_enable ##1
		!interrupt_pin_config_q.calibration_out_enable |-> !cal_out)
		else $error("calibration output toggles while disabled");

	a_restore_sets: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(src_sync_q) |=> pm_irq_flags_q[FLAG_SUPPLY_RESTORED])
		else $error("supply restored flag missed");

	a_switch_sets: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(src_sync_q) |=> pm_irq_flags_q[FLAG_BATTERY_SWITCH])
		else $error("battery switchover flag missed");

	a_sag_sets: assert property (@(posedge clock) disable iff (!reset_n)
		monitor_events.sag |=> pm_irq_flags_q[FLAG_VOLTAGE_SAG])
		else $error("sag flag missed");

	a_monitor_sets: assert property (@(posedge clock) disable iff (!reset_n)
		monitor_events.bat_low || monitor_events.bat_ready
		|=> pm_irq_flags_q[FLAG_BATTERY_MONITOR])
		else $error("battery monitor flag missed");

	a_dc_adc_sets: assert property (@(posedge clock) disable iff (!reset_n)
		monitor_events.dc_delta || monitor_events.dc_ready
		|=> pm_irq_flags_q[FLAG_DC_INPUT_ADC])
		else $error("dc input adc flag missed");

	a_dc_low_sets: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(dcl_sync_q) |=> pm_irq_flags_q[FLAG_DC_INPUT_LOW])
		else $error("dc input low flag missed");

	a_flag_sticks: assert property (@(posedge clock) disable iff (!reset_n)
		pm_irq_flags_q[FLAG_VOLTAGE_SAG] &&
		!(sfr_we && sfr_addr == ADDR_PM_IRQ_FLAGS && !sfr_wdata[FLAG_VOLTAGE_SAG])
		|=> pm_irq_flags_q[FLAG_VOLTAGE_SAG])
		else $error("sag flag dropped without a clearing write");

	a_power_save_gate: assert property (@(posedge clock) disable iff (!reset_n)
		|(pm_irq_flags_q & pm_irq_enable_q & EVENT_ONLY_MASK) |-> power_save_irq)
		else $error("enabled flag active without power-save flag");

	a_irq1_decode: assert property (@(posedge clock) disable iff (!reset_n)
		ext_irq1_input_enable |-> !ext_irq1_gpio_select && !battery_control_input)
		else $error("irq1 enabled while pin assigned to another function");

	a_flag_clears: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_we && sfr_addr == ADDR_PM_IRQ_FLAGS && !sfr_wdata[FLAG_VOLTAGE_SAG] &&
		!monitor_events.sag |=> !pm_irq_flags_q[FLAG_VOLTAGE_SAG])
		else $error("sag flag survived a clearing write");

	a_one_keeps: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_we && sfr_addr == ADDR_PM_IRQ_FLAGS && sfr_wdata[FLAG_BATTERY_MONITOR] &&
		pm_irq_flags_q[FLAG_BATTERY_MONITOR] |=> pm_irq_flags_q[FLAG_BATTERY_MONITOR])
		else $error("battery monitor flag lost on a write of one");

	a_key_lands: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_we && sfr_addr == ADDR_WRITE_KEY
		|=> write_key_register_q == $past(sfr_wdata))
		else $error("key register write not taken");

	a_read_holds: assert property (@(posedge clock) disable iff (!reset_n)
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");

	a_read_flags: assert property (@(posedge clock) disable iff (!reset_n)
		sfr_rd && sfr_addr == ADDR_PM_IRQ_FLAGS
		|=> sfr_rdata == $past(pm_irq_flags_q))
		else $error("flag read returned a wrong value");

	a_reserved_low: assert property (@(posedge clock) disable iff (!reset_n)
		!pm_irq_flags_q[FLAG_RESERVED] && !interrupt_pin_config_q.reserved &&
		(pm_irq_enable_q & ~ENABLE_WRITE_MASK) == 8'h00)
		else $error("reserved register bit found set");

endmodule : pmfpc_top

/* File: bench/pmfpc_monitor_model.sv */
`timescale 1ns/10ps
module pmfpc_monitor_model
	import pmfpc_pkg::*;
(
	input  wire logic  clock,
	output logic       supply_source_main,
	output logic       dc_input_low,
	output pmfpc_evt_t monitor_events
);
	// start on main supply with the dc input healthy
	initial begin
		supply_source_main = 1'b1;
		dc_input_low = 1'b0;
		monitor_events = '0;
	end
	// one-cycle event pulses; held longer they would look like repeat events
	task automatic pulse(input pmfpc_evt_t e);
		@(posedge clock);
		monitor_events <= e;
		@(posedge clock);
		monitor_events <= '0;
	endtask : pulse
	// analog levels move after an edge and stay put until told otherwise
	task automatic set_levels(input logic src, input logic low);
		@(posedge clock);
		supply_source_main <= src;
		dc_input_low <= low;
	endtask : set_levels
endmodule : pmfpc_monitor_model

/* File: bench/power_mgmt_flags_and_pin_config_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module power_mgmt_flags_and_pin_config_bench;
	import pmfpc_pkg::*;
	logic       clock, reset_n, sfr_we, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic       supply_source_main, dc_input_low, cal_out, cal_out_oe;
	logic       ext_irq0_input_enable, ext_irq1_input_enable, ext_irq1_gpio_select;
	logic       battery_control_input, power_save_irq;
	logic [7:0] power_control, peripheral_config, battery_switch_config;
	pmfpc_evt_t monitor_events;
	int         checks = 0;
	int         miscompares = 0;
	logic [7:0] ra[11] = '{8'hc1, 8'hc5, 8'hec, 8'hf4, 8'hf5, 8'hf8, 8'hfb, 8'hfc,
		8'hfd, 8'hfe, 8'hff};
	int         half[4] = '{5, 7, 9, 781};
	int         fp[5] = '{2, 2, 3, 3, 5};

	initial clock = 1'b0;
	always #20 clock = ~clock;

	pmfpc_top #(.HALF_SLOW_CNT(5), .HALF_512_CNT(7), .HALF_500_CNT(9)) DUT (
		.clock, .reset_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_rd, .sfr_rdata,
		.supply_source_main, .dc_input_low, .monitor_events, .cal_out, .cal_out_oe,
		.ext_irq0_input_enable, .ext_irq1_input_enable, .ext_irq1_gpio_select,
		.battery_control_input, .power_save_irq, .power_control, .peripheral_config,
		.battery_switch_config
	);

	pmfpc_monitor_model MON (
		.clock, .supply_source_main, .dc_input_low, .monitor_events
	);

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_we <= 1'b1;
		@(posedge clock);
		sfr_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		#1;
		`CHK(nm, ex, sfr_rdata)
	endtask : rd

	// unlock, write, relock: the key is never left open
	task automatic cfg(input logic [7:0] v);
		wr(ADDR_WRITE_KEY, KEY_UNLOCK);
		wr(ADDR_INTERRUPT_PIN, v);
		wr(ADDR_WRITE_KEY, 8'h00);
		#1;
	endtask : cfg

	// cycles until cal_out next changes, bounded so a dead output cannot hang
	task automatic tog(output int n);
		logic last;
		last = cal_out;
		n = 0;
		while (cal_out === last && n < 2000) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask : tog

	task automatic conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		conclude();
	end

	initial begin
		logic [3:0] b;
		int         n;
		reset_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_we = 1'b0;
		sfr_rd = 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		foreach (ra[i]) rd(ra[i], 8'h00, "reset_val");
		`CHK("gpio_sel", 1'b1, ext_irq1_gpio_select)
		`CHK("cal_idle", 1'b0, cal_out)
		// plain storage registers, pattern differs per address
		for (int i = 1; i < 10; i++) begin
			if (i != 2 && i != 5) wr(ra[i], ra[i] ^ 8'h96);
		end
		for (int i = 1; i < 10; i++) begin
			if (i != 2 && i != 5) rd(ra[i], ra[i] ^ 8'h96, "storage");
		end
		`CHK("pwr_ctl", 8'h53, power_control)
		`CHK("peripheral_config", 8'h62, peripheral_config)
		`CHK("bat_cfg", 8'h63, battery_switch_config)
		wr(8'h80, 8'hff);
		rd(8'h80, 8'h00, "unmapped");
		wr(ADDR_PM_IRQ_ENABLE, 8'hff);
		rd(ADDR_PM_IRQ_ENABLE, 8'haf, "en_rsvd");
		wr(ADDR_PM_IRQ_ENABLE, 8'h00);
		// pin config guarded by the key
		wr(ADDR_INTERRUPT_PIN, 8'h80);
		rd(ADDR_INTERRUPT_PIN, 8'h00, "locked");
		wr(ADDR_WRITE_KEY, 8'heb);
		wr(ADDR_INTERRUPT_PIN, 8'h80);
		rd(ADDR_INTERRUPT_PIN, 8'h00, "bad_key");
		wr(ADDR_WRITE_KEY, KEY_UNLOCK);
		rd(ADDR_WRITE_KEY, KEY_UNLOCK, "key_rd");
		wr(ADDR_INTERRUPT_PIN, 8'h80);
		rd(ADDR_INTERRUPT_PIN, 8'h80, "unlocked");
		`CHK("cal_oe", 1'b1, cal_out_oe)
		wr(ADDR_WRITE_KEY, 8'h00);
		wr(ADDR_INTERRUPT_PIN, 8'h00);
		rd(ADDR_INTERRUPT_PIN, 8'h80, "relocked");
		// every irq pin function code, reserved bit 4 written high
		for (int v = 0; v < 16; v++) begin
			b = 4'(v);
			cfg({4'h1, b});
			rd(ADDR_INTERRUPT_PIN, {4'h0, b}, "pin_cfg");
			`CHK("irq0_en", b[0], ext_irq0_input_enable)
			`CHK("irq1_en", b[3:2] == 2'b11, ext_irq1_input_enable)
			`CHK("gpio", b[2:1] == 2'b00, ext_irq1_gpio_select)
			`CHK("bat_ctl", b[2:1] == 2'b01, battery_control_input)
		end
		// calibration output: skip two edges so a select change has landed
		for (int i = 0; i < 4; i++) begin
			cfg({1'b1, 2'(i), 5'h00});
			`CHK("cal_oe", 1'b1, cal_out_oe)
			tog(n);
			tog(n);
			tog(n);
			`CHK("half_per", half[i], n)
		end
		cfg(8'h00);
		repeat (4) @(posedge clock);
		#1;
		`CHK("cal_off", 1'b0, cal_out)
		`CHK("cal_oe_off", 1'b0, cal_out_oe)
		// event flags with every enable clear
		for (int i = 0; i < 5; i++) begin
			MON.pulse(pmfpc_evt_t'(5'(1) << i));
			rd(ADDR_PM_IRQ_FLAGS, 8'(1) << fp[i], "flag_set");
			wr(ADDR_PM_IRQ_FLAGS, FLAG_WRITE_MASK);
			rd(ADDR_PM_IRQ_FLAGS, 8'(1) << fp[i], "flag_keep");
			`CHK("save_off", 1'b0, power_save_irq)
			wr(ADDR_PM_IRQ_FLAGS, 8'h00);
			rd(ADDR_PM_IRQ_FLAGS, 8'h00, "flag_clr");
		end
		wr(ADDR_PM_IRQ_ENABLE, 8'h20);
		MON.pulse(pmfpc_evt_t'(5'h10));
		rd(ADDR_PM_IRQ_FLAGS, 8'h60, "save_set");
		`CHK("save_on", 1'b1, power_save_irq)
		wr(ADDR_PM_IRQ_FLAGS, 8'h00);
		rd(ADDR_PM_IRQ_FLAGS, 8'h00, "save_clr");
		wr(ADDR_PM_IRQ_ENABLE, 8'h02);
		MON.pulse(pmfpc_evt_t'(5'h10));
		rd(ADDR_PM_IRQ_FLAGS, 8'h20, "gated");
		// enabling a flag that is already pending raises the power-save flag
		wr(ADDR_PM_IRQ_ENABLE, 8'h20);
		rd(ADDR_PM_IRQ_FLAGS, 8'h60, "late_en");
		wr(ADDR_PM_IRQ_ENABLE, 8'h02);
		wr(ADDR_PM_IRQ_FLAGS, 8'h00);
		// supply source and dc input levels go through synchronisers
		MON.set_levels(1'b0, 1'b0);
		repeat (6) @(posedge clock);
		rd(ADDR_PM_IRQ_FLAGS, 8'h42, "to_bat");
		`CHK("save_bat", 1'b1, power_save_irq)
		wr(ADDR_PM_IRQ_FLAGS, 8'h00);
		MON.set_levels(1'b1, 1'b0);
		repeat (6) @(posedge clock);
		rd(ADDR_PM_IRQ_FLAGS, 8'h80, "to_main");
		wr(ADDR_PM_IRQ_FLAGS, 8'h00);
		MON.set_levels(1'b1, 1'b1);
		repeat (6) @(posedge clock);
		rd(ADDR_PM_IRQ_FLAGS, 8'h01, "dc_low");
		wr(ADDR_PM_IRQ_FLAGS, 8'h00);
		rd(ADDR_PM_IRQ_FLAGS, 8'h00, "dc_clr");
		conclude();
	end
endmodule : power_mgmt_flags_and_pin_config_bench
